// ---- bench/ssb_bus_master.sv ----
// bus master model driving the sram's synchronous inputs
`timescale 1ns/1ns
module ssb_bus_master
  import ssb_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // address and control
  output logic [SSB_ADDR_W-1:0] word_addr,
  output logic chip_en_n,
  output logic cpu_transfer_start_n,
  output logic cache_ctl_transfer_start_n,
  output logic burst_advance_n,
  output logic low_byte_wr_n,
  output logic high_byte_wr_n,
  output logic out_en_n,
  // write data toward the sram
  output logic [SSB_DATA_W-1:0] wdata
);
  initial begin
    {chip_en_n, cpu_transfer_start_n, cache_ctl_transfer_start_n} = 3'h7;
    {burst_advance_n, low_byte_wr_n, high_byte_wr_n, out_en_n} = 4'hF;
    word_addr = 15'h0000;
    wdata = 18'h00000;
  end
  // one bus cycle, launched just after the edge and held for a full period
  task automatic drive(input logic ce_n, cpu_n, cc_n, adv_n, lo_n, hi_n, oe_n,
      input logic [SSB_ADDR_W-1:0] addr, input logic [SSB_DATA_W-1:0] data);
    logic wr;
    // a cpu start is a read whatever the strobes show
    wr = cpu_n && !(lo_n && hi_n);
    @(posedge sys_clk);
    #1;
    word_addr = addr;
    {chip_en_n, cpu_transfer_start_n, cache_ctl_transfer_start_n} = {ce_n, cpu_n, cc_n};
    {burst_advance_n, low_byte_wr_n, high_byte_wr_n} = {adv_n, lo_n, hi_n};
    // released lines toggle, so a stale copy never looks valid
    wdata = wr ? data : ~wdata;
    out_en_n = wr ? 1'b1 : oe_n;
  endtask
endmodule

// ---- bench/tb_sync_burst_sram_control.sv ----
// self-checking testbench of the burst sram control block
`timescale 1ns/1ns
module tb_sync_burst_sram_control;
  import ssb_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  wire logic [SSB_ADDR_W-1:0] word_addr;
  wire logic ce_n, cpu_n, cc_n, adv_n, lo_n, hi_n, oe_n;
  wire logic [SSB_DATA_W-1:0] d_in;
  wire logic [SSB_DATA_W-1:0] d_out;
  wire logic d_oe;
  logic [SSB_DATA_W-1:0] ref_mem [int];
  logic [SSB_DATA_W-1:0] exp_q [$];
  int n_mismatch = 0;
  int n_tests = 0;
  int seed_dummy;
  logic sel = 1'b0;
  logic hide = 1'b0;
  logic [SSB_ADDR_W-1:0] cur = 15'h0000;
  logic [SSB_ADDR_W-1:0] base;
  // reads waiting for the cycle whose enable decides whether they show
  logic pv0 = 1'b0;
  logic pv1 = 1'b0;
  logic [SSB_DATA_W-1:0] pd0 = 18'h00000;
  logic [SSB_DATA_W-1:0] pd1 = 18'h00000;

  always #2 sys_clk = ~sys_clk;

  ssb_sram_ctl u_dut (.sys_clk(sys_clk), .rstn(rstn), .word_addr(word_addr), .chip_en_n(ce_n),
    .cpu_transfer_start_n(cpu_n), .cache_ctl_transfer_start_n(cc_n), .burst_advance_n(adv_n),
    .low_byte_wr_n(lo_n), .high_byte_wr_n(hi_n), .out_en_n(oe_n), .shared_data_bus_i(d_in),
    .shared_data_bus_o(d_out), .shared_data_bus_oe(d_oe));
  ssb_bus_master u_mst (.sys_clk(sys_clk), .word_addr(word_addr), .chip_en_n(ce_n),
    .cpu_transfer_start_n(cpu_n), .cache_ctl_transfer_start_n(cc_n), .burst_advance_n(adv_n),
    .low_byte_wr_n(lo_n), .high_byte_wr_n(hi_n), .out_en_n(oe_n), .wdata(d_in));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [SSB_DATA_W-1:0] exp, input logic [SSB_DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // any drive of the pins must match the oldest pending read
  always @(negedge sys_clk) begin
    if (d_oe !== 1'b0) begin
      if (exp_q.size() == 0) check(18'h00000, {SSB_DATA_W{d_oe}});
      else check(exp_q.pop_front(), d_out);
    end
  end

  // ----------------------------------------
  // stimulus with reference model
  // ----------------------------------------
  task automatic cyc(input logic e, p, c, a, l, h, input logic [SSB_ADDR_W-1:0] addr,
      input logic [SSB_DATA_W-1:0] data);
    logic wr;
    logic rd_now;
    logic [SSB_DATA_W-1:0] rd_val;
    if (!p || !c) begin
      sel = !e;
      cur = addr;
      wr = p && !(l && h);
    end else begin
      if (sel && !a) cur[1:0] = cur[1:0] + 2'h1;
      wr = !(l && h);
    end
    rd_now = 1'b0;
    rd_val = 18'h00000;
    if (sel && wr) begin
      if (!l) ref_mem[cur][8:0] = data[8:0];
      if (!h) ref_mem[cur][17:9] = data[17:9];
    end else if (sel) begin
      rd_now = 1'b1;
      rd_val = ref_mem[cur];
    end
    // read data stands two cycles on, under the enable of that later cycle
    if (pv1 && !(p && !(l && h)) && !hide) exp_q.push_back(pd1);
    pv1 = pv0;
    pd1 = pd0;
    pv0 = rd_now;
    pd0 = rd_val;
    u_mst.drive(e, p, c, a, l, h, hide, addr, data);
  endtask

  // deselecting start: keeps reads away from a following write
  task automatic idle2();
    repeat (2) cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 15'($urandom), 18'($urandom));
  endtask

  task automatic report_and_stop();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    seed_dummy = $urandom(32'h9703C20C);
    repeat (10) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    // fill two lines by burst writes, chip enable ignored in continuation
    for (int k = 0; k < 2; k++) begin
      base = {13'($urandom), 2'h0};
      idle2();
      cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, base, 18'($urandom));
      // fourth advance wraps onto the start word
      repeat (4) cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 15'($urandom), 18'($urandom));
    end
    $display("test fill done");
    // burst reads from every start with a suspend and a wrap
    for (int s = 0; s < 4; s++) begin
      cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, {base[14:2], 2'(s)}, 18'h00000);
      cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 15'($urandom), 18'h00000);
      cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 15'($urandom), 18'h00000);
      repeat (3) cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 15'($urandom), 18'h00000);
    end
    $display("test burst read done");
    // cpu start with strobes low aborts the burst and reads
    cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, {base[14:2], 2'h2}, 18'($urandom));
    cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 15'h0000, 18'h00000);
    $display("test cpu abort done");
    // two-cycle cpu writes with each strobe set, then read back
    for (int b = 1; b < 4; b++) begin
      idle2();
      cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, base, 18'h00000);
      cyc(1'b1, 1'b1, 1'b1, 1'b1, !b[0], !b[1], 15'($urandom), 18'($urandom));
      cyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, base, 18'h00000);
    end
    $display("test byte write done");
    // deselected start and continuation must not write
    idle2();
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, base, 18'($urandom));
    cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, base, 18'($urandom));
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, base, 18'h00000);
    $display("test deselect done");
    // read with output enable high stays off the pins
    hide = 1'b1;
    cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, base, 18'h00000);
    idle2();
    hide = 1'b0;
    idle2();
    check(18'h00000, 18'(exp_q.size()));
    $display("test output enable done");
    report_and_stop();
  end
endmodule

// ---- logic/ssb_array.sv ----
// 32k by 18 storage array with byte writes and registered read data
`timescale 1ns/1ns
module ssb_array
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // access
  input wire logic rd_en,
  input wire logic [SSB_BYTES-1:0] byte_we,
  input wire logic [SSB_ADDR_W-1:0] addr,
  input wire logic [SSB_DATA_W-1:0] wdata,
  // read data
  output logic [SSB_DATA_W-1:0] rdata_r
);

  wire logic [SSB_DATA_W-1:0] rd_word;

  genvar b;
  generate
    for (b = 0; b < SSB_BYTES; b++) begin : g_byte
      // one store per lane, so each lane has a single writer
      // no reset on the store: contents are undefined after power up
      logic [SSB_BYTE_W-1:0] mem [SSB_WORDS];
      always_ff @(posedge sys_clk) begin
        if (byte_we[b]) begin
          mem[addr] <= wdata[b*SSB_BYTE_W +: SSB_BYTE_W];
        end
      end
      assign rd_word[b*SSB_BYTE_W +: SSB_BYTE_W] = mem[addr];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= SSB_DATA_RST;
    end else if (rd_en) begin
      rdata_r <= rd_word;
    end
  end

endmodule

// ---- logic/ssb_burst_ctr.sv ----
// two-bit wrapping burst counter for the low address bits
`timescale 1ns/1ns
module ssb_burst_ctr
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic load,
  input wire logic [SSB_CNT_W-1:0] load_val,
  input wire logic advance,
  // access address low bits for this cycle
  output logic [SSB_CNT_W-1:0] acc_lo
);

  logic [SSB_CNT_W-1:0] cnt_r;
  logic [SSB_CNT_W-1:0] cnt_nxt;

  // linear order; modulo-four overflow gives the wrap to the start value
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (advance) begin
      cnt_nxt = cnt_r + SSB_CNT_STEP;
    end
  end

  assign acc_lo = cnt_nxt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= SSB_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ---- logic/ssb_sram_ctl.sv ----
// top of the synchronous burst sram: input registers, burst control, array and data pins
`timescale 1ns/1ns
module ssb_sram_ctl
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // address and burst control
  input wire logic [SSB_ADDR_W-1:0] word_addr,
  input wire logic chip_en_n,
  input wire logic cpu_transfer_start_n,
  input wire logic cache_ctl_transfer_start_n,
  input wire logic burst_advance_n,
  // byte write strobes
  input wire logic low_byte_wr_n,
  input wire logic high_byte_wr_n,
  // asynchronous output enable
  input wire logic out_en_n,
  // shared data bus, split into in, out and enable
  input wire logic [SSB_DATA_W-1:0] shared_data_bus_i,
  output logic [SSB_DATA_W-1:0] shared_data_bus_o,
  output logic shared_data_bus_oe
);

  // ----------------------------------------
  // input registers
  // ----------------------------------------
  ssb_sample_t smp_r;
  ssb_sample_t smp_nxt;

  always_comb begin
    smp_nxt.addr = word_addr;
    smp_nxt.data = shared_data_bus_i;
    smp_nxt.chip_en_n = chip_en_n;
    smp_nxt.cpu_ts_n = cpu_transfer_start_n;
    smp_nxt.cc_ts_n = cache_ctl_transfer_start_n;
    smp_nxt.adv_n = burst_advance_n;
    smp_nxt.lo_wr_n = low_byte_wr_n;
    smp_nxt.hi_wr_n = high_byte_wr_n;
  end

  // output enable is kept out of this path on purpose
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      smp_r <= SSB_SAMPLE_RST;
    end else begin
      smp_r <= smp_nxt;
    end
  end

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  logic start_cpu;
  logic start_cc;
  logic start_any;
  logic cont;
  logic any_strobe;
  logic [SSB_BYTES-1:0] strobe_be;

  // cpu start outranks cache start and ignores the strobes
  assign start_cpu = !smp_r.cpu_ts_n;
  assign start_cc = smp_r.cpu_ts_n && !smp_r.cc_ts_n;
  assign start_any = start_cpu || start_cc;
  assign cont = smp_r.cpu_ts_n && smp_r.cc_ts_n;
  assign strobe_be[SSB_LO_BYTE] = !smp_r.lo_wr_n;
  assign strobe_be[SSB_HI_BYTE] = !smp_r.hi_wr_n;
  assign any_strobe = |strobe_be;

  // ----------------------------------------
  // burst state
  // ----------------------------------------
  ssb_state_t state_r;
  ssb_state_t state_nxt;
  logic [SSB_ADDR_W-1:SSB_CNT_W] base_hi_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSB_ST_IDLE: begin
        if (start_any && !smp_r.chip_en_n) begin
          state_nxt = SSB_ST_BURST;
        end
      end
      SSB_ST_BURST: begin
        if (start_any && smp_r.chip_en_n) begin
          state_nxt = SSB_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SSB_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // upper bits change only when a selected start loads a base
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      base_hi_r <= SSB_ADDR_RST[SSB_ADDR_W-1:SSB_CNT_W];
    end else if (start_any && !smp_r.chip_en_n) begin
      base_hi_r <= smp_r.addr[SSB_ADDR_W-1:SSB_CNT_W];
    end
  end

  // ----------------------------------------
  // access decision
  // ----------------------------------------
  logic acc_sel;
  logic acc_wr;
  logic acc_rd;
  logic [SSB_CNT_W-1:0] acc_lo;
  logic [SSB_ADDR_W-1:0] acc_addr;
  logic [SSB_BYTES-1:0] acc_be;

  // chip enable matters only on starts; continuation follows the burst state
  assign acc_sel = start_any ? !smp_r.chip_en_n : (state_r == SSB_ST_BURST);
  assign acc_wr = acc_sel && !start_cpu && any_strobe;
  assign acc_rd = acc_sel && !acc_wr;
  assign acc_be = acc_wr ? strobe_be : SSB_BE_NONE;

  ssb_burst_ctr u_ctr (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(start_any),
    .load_val(smp_r.addr[SSB_CNT_W-1:0]),
    .advance(cont && acc_sel && !smp_r.adv_n),
    .acc_lo(acc_lo)
  );

  assign acc_addr = start_any ? smp_r.addr : {base_hi_r, acc_lo};

  // ----------------------------------------
  // array; the write is one clock edge, no external pulse
  // ----------------------------------------
  ssb_array u_array (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rd_en(acc_rd),
    .byte_we(acc_be),
    .addr(acc_addr),
    .wdata(smp_r.data),
    .rdata_r(shared_data_bus_o)
  );

  // ----------------------------------------
  // data pin drive
  // ----------------------------------------
  logic drive_r;
  logic acc_wr_r;
  logic acc_any_r;
  logic [SSB_ADDR_W-1:0] acc_addr_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= acc_rd;
    end
  end

  // helper history of the last access, for the checks below
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_wr_r <= 1'b0;
      acc_any_r <= 1'b0;
      acc_addr_r <= SSB_ADDR_RST;
    end else begin
      acc_wr_r <= acc_wr;
      acc_any_r <= acc_sel;
      acc_addr_r <= acc_addr;
    end
  end

  // enable is gated by the pin with no register, so it follows it at once
  assign shared_data_bus_oe = drive_r && !out_en_n;

  // ----------------------------------------
  // burst beat history for the order checks
  // ----------------------------------------
  localparam logic [SSB_CNT_W:0] BEAT_ONE = {{SSB_CNT_W{1'b0}}, 1'b1};
  logic [SSB_CNT_W:0] beats_r;
  logic [SSB_ADDR_W-1:0] start_addr_r;

  // one bit wider than the counter, so a full wrap is told apart from the start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      beats_r <= '0;
      start_addr_r <= SSB_ADDR_RST;
    end else if (start_any && !smp_r.chip_en_n) begin
      beats_r <= '0;
      start_addr_r <= smp_r.addr;
    end else if (cont && acc_sel && !smp_r.adv_n) begin
      beats_r <= beats_r + BEAT_ONE;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_input_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (smp_r.addr == $past(word_addr) && smp_r.lo_wr_n == $past(low_byte_wr_n)))
    else $error("inputs not captured at the clock edge");

  chk_cpu_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_cpu && !smp_r.chip_en_n) |=> (!acc_wr_r && acc_any_r && acc_addr_r == $past(smp_r.addr)))
    else $error("cpu start did not read at the external address");

  chk_cache_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_cc && !smp_r.chip_en_n) |=> (acc_wr_r == $past(any_strobe)))
    else $error("cache start access kind wrong");

  chk_deselect_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_any && smp_r.chip_en_n) |=> (!acc_any_r && !shared_data_bus_oe))
    else $error("deselecting start still accessed or drove");

  chk_desel_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r == SSB_ST_IDLE && !start_any) |=> !acc_any_r)
    else $error("deselected device accessed the array");

  chk_advance_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc_any_r && cont && acc_sel && !smp_r.adv_n)
      |=> (acc_addr_r[SSB_CNT_W-1:0] == $past(acc_addr_r[SSB_CNT_W-1:0]) + SSB_CNT_STEP))
    else $error("advance did not step the low address");

  chk_suspend_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc_any_r && cont && acc_sel && smp_r.adv_n) |=> $stable(acc_addr_r))
    else $error("suspend moved the address");

  chk_upper_fixed: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc_any_r && cont && acc_sel) |=> (acc_addr_r[SSB_ADDR_W-1:SSB_CNT_W] ==
      $past(acc_addr_r[SSB_ADDR_W-1:SSB_CNT_W])))
    else $error("upper address changed inside a burst");

  chk_wrap_four: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_cc && !smp_r.chip_en_n) ##1 (cont && !smp_r.adv_n) [*4]
      |=> (acc_addr_r == $past(acc_addr_r, 4)))
    else $error("burst did not wrap to its start");

  chk_write_float: assert property (@(posedge sys_clk) disable iff (!rstn)
    acc_wr_r |-> !shared_data_bus_oe)
    else $error("pins driven during a write");

  chk_read_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc_rd && !acc_wr) ##1 !out_en_n |-> shared_data_bus_oe)
    else $error("read with output enable low not driven");

  chk_release_float: assert property (@(posedge sys_clk)
    $rose(rstn) |-> !shared_data_bus_oe)
    else $error("pins driven right after reset");

  chk_data_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (smp_r.data == $past(shared_data_bus_i) && smp_r.hi_wr_n == $past(high_byte_wr_n)))
    else $error("data or high strobe not captured");

  chk_start_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (smp_r.cpu_ts_n == $past(cpu_transfer_start_n) &&
      smp_r.cc_ts_n == $past(cache_ctl_transfer_start_n)))
    else $error("start inputs not captured");

  chk_ctl_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (smp_r.chip_en_n == $past(chip_en_n) && smp_r.adv_n == $past(burst_advance_n)))
    else $error("chip enable or advance not captured");

  chk_cpu_no_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_cpu |-> (acc_be == SSB_BE_NONE))
    else $error("cpu start wrote the array");

  chk_cache_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_cc && !smp_r.chip_en_n) |=> (acc_any_r && acc_addr_r == $past(smp_r.addr)))
    else $error("cache start not at the external address");

  chk_select_state: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_any && !smp_r.chip_en_n) |=> (state_r == SSB_ST_BURST))
    else $error("selected start did not begin a burst");

  chk_deselect_state: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start_any && smp_r.chip_en_n) |=> (state_r == SSB_ST_IDLE))
    else $error("deselecting start left the burst running");

  chk_cont_ignores_ce: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cont && state_r == SSB_ST_BURST) |-> acc_sel)
    else $error("chip enable used during continuation");

  chk_cont_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cont && acc_sel && any_strobe) |-> (acc_wr && acc_be == strobe_be))
    else $error("continuation with strobe did not write");

  chk_cont_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cont && acc_sel && !any_strobe) |=> (drive_r && !acc_wr_r))
    else $error("continuation without strobe did not read");

  chk_byte_lanes: assert property (@(posedge sys_clk) disable iff (!rstn)
    acc_wr |-> (acc_be == strobe_be && acc_be != SSB_BE_NONE))
    else $error("write lanes differ from strobes");

  chk_lane_split: assert property (@(posedge sys_clk) disable iff (!rstn)
    acc_wr |-> (acc_be[SSB_LO_BYTE] == !smp_r.lo_wr_n &&
      acc_be[SSB_HI_BYTE] == !smp_r.hi_wr_n))
    else $error("strobe drives the wrong lane");

  chk_write_one_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
    acc_wr |=> (acc_wr_r && !drive_r))
    else $error("write not done in one clock");

  chk_start_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_any |-> (acc_addr == smp_r.addr))
    else $error("start did not use the external address");

  chk_linear_order: assert property (@(posedge sys_clk) disable iff (!rstn)
    acc_any_r |-> (acc_addr_r[SSB_CNT_W-1:0] ==
      start_addr_r[SSB_CNT_W-1:0] + beats_r[SSB_CNT_W-1:0] &&
      acc_addr_r[SSB_ADDR_W-1:SSB_CNT_W] == start_addr_r[SSB_ADDR_W-1:SSB_CNT_W]))
    else $error("burst address not in linear order");

  chk_wrap_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc_any_r && beats_r[SSB_CNT_W] && beats_r[SSB_CNT_W-1:0] == SSB_CNT_RST)
      |-> (acc_addr_r == start_addr_r))
    else $error("fourth advance did not return to the start");

  chk_oe_pin_float: assert property (@(posedge sys_clk) disable iff (!rstn)
    out_en_n |-> !shared_data_bus_oe)
    else $error("pins driven with output enable high");

  chk_drive_once: assert property (@(posedge sys_clk) disable iff (!rstn)
    drive_r |-> $past(acc_rd))
    else $error("drive without a read");

  chk_float_no_access: assert property (@(posedge sys_clk) disable iff (!rstn)
    !acc_any_r |-> !shared_data_bus_oe)
    else $error("pins driven with no access");

  chk_desel_no_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    !acc_sel |-> (acc_be == SSB_BE_NONE))
    else $error("deselected device wrote the array");

endmodule

// ---- pkg/ssb_pkg.sv ----
// constants and types of the synchronous burst sram control block
// How it works
// - address, data and all controls but output enable are registered on the rising clock
// - array holds 32,768 words of 18 bits on a 15-bit address and shared data bus
// - low strobe owns data bits 0..8, high strobe owns bits 9..17
// - a 2-bit burst counter makes the low address bits after the first access
// - writes start at the clock edge and are timed inside, no write pulse needed
// - cpu start with chip selected forces a read at the new external address
// - cache start with cpu start high begins a burst; write if any strobe low
// - chip enable sampled only on a start; high there deselects the device
// - in continuation, advance low increments the internal address before the access
// - in continuation, advance high repeats the access at the same address
// - after four advanced beats the low bits wrap back to the loaded start
// - external low two bits start the burst; upper address bits stay fixed
// - continuation cycle is a write if a strobe is low, else a read
// - only bytes with low strobes are written; the other byte keeps its value
// - output enable acts asynchronously; pins drive only on reads with it low
// - data pins stay high impedance from power up until a read drives them
package ssb_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int unsigned SSB_ADDR_W = 15;
  localparam int unsigned SSB_DATA_W = 18;
  localparam int unsigned SSB_WORDS = 32768;
  localparam int unsigned SSB_BYTES = 2;
  localparam int unsigned SSB_BYTE_W = 9;
  localparam int unsigned SSB_CNT_W = 2;
  localparam int unsigned SSB_LO_BYTE = 0;
  localparam int unsigned SSB_HI_BYTE = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [SSB_CNT_W-1:0] SSB_CNT_RST = 2'h0;
  localparam logic [SSB_CNT_W-1:0] SSB_CNT_STEP = 2'h1;
  localparam logic [SSB_ADDR_W-1:0] SSB_ADDR_RST = 15'h0000;
  localparam logic [SSB_DATA_W-1:0] SSB_DATA_RST = 18'h00000;
  localparam logic [SSB_BYTES-1:0] SSB_BE_NONE = 2'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [0:0] {
    SSB_ST_IDLE = 1'b0,
    SSB_ST_BURST = 1'b1
  } ssb_state_t;

  typedef struct packed {
    logic [SSB_ADDR_W-1:0] addr;
    logic [SSB_DATA_W-1:0] data;
    logic chip_en_n;
    logic cpu_ts_n;
    logic cc_ts_n;
    logic adv_n;
    logic lo_wr_n;
    logic hi_wr_n;
  } ssb_sample_t;

  localparam ssb_sample_t SSB_SAMPLE_RST = '{
    addr: SSB_ADDR_RST,
    data: SSB_DATA_RST,
    chip_en_n: 1'b1,
    cpu_ts_n: 1'b1,
    cc_ts_n: 1'b1,
    adv_n: 1'b1,
    lo_wr_n: 1'b1,
    hi_wr_n: 1'b1
  };

endpackage
